// ---- hw/rco_frac_div.sv ----
// Fractional half-period divider that turns source ticks into a glitch-free output clock.
module rco_frac_div
  import rco_pkg::*;
#(
  parameter int unsigned DW = rco_pkg::DIV_W,
  parameter int unsigned TW = rco_pkg::TRIM_W
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          run,
  input  wire logic [DW-1:0] divisor,
  input  wire logic [TW-1:0] trim,
  output logic               clk_level,
  output logic               fall,
  output logic               stopped
);
  logic [DW:0]   count;
  logic [DW:0]   half_len;
  logic [TW-1:0] acc;
  logic [TW:0]   acc_sum;
  logic          toggle;
  logic          going;

  // A stop is deferred until the output sits low, so no runt pulse escapes.
  assign going = run | clk_level;
  assign toggle = going & tick & ((count + 1'b1) >= half_len);
  assign fall = toggle & clk_level;
  assign stopped = ~run & ~clk_level;
  assign acc_sum = {1'b0, acc} + {1'b0, trim};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      acc <= '0;
      half_len <= '0;
      clk_level <= 1'b0;
    end else if (!going) begin
      count <= '0;
      acc <= '0;
      half_len <= (divisor == '0) ? {{DW{1'b0}}, 1'b1} : {1'b0, divisor};
      clk_level <= 1'b0;
    end else if (toggle) begin
      count <= '0;
      clk_level <= ~clk_level;
      if (divisor == '0) begin
        acc <= '0;
        half_len <= {{DW{1'b0}}, 1'b1};
      end else begin
        acc <= acc_sum[TW-1:0];
        half_len <= {1'b0, divisor} + {{DW{1'b0}}, acc_sum[TW]};
      end
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end
endmodule

// ---- hw/rco_pkg.sv ----
// Package with the register map, field layout and source codes of the reference clock output.
package rco_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DIV_W = 15;
  localparam int unsigned TRIM_W = 9;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned NUM_SRC = 10;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TRIM = 8'h04;

  localparam int unsigned POS_DIV_LO = 16;
  localparam int unsigned POS_DIV_HI = 30;
  localparam int unsigned POS_ON = 15;
  localparam int unsigned POS_STOP_IN_IDLE = 13;
  localparam int unsigned POS_OE = 12;
  localparam int unsigned POS_RUN_IN_SLEEP = 11;
  localparam int unsigned POS_SWITCH = 9;
  localparam int unsigned POS_ACTIVE = 8;
  localparam int unsigned POS_SEL_LO = 0;
  localparam int unsigned POS_SEL_HI = 3;
  localparam int unsigned POS_TRIM_LO = 23;
  localparam int unsigned POS_TRIM_HI = 31;

  localparam logic [DIV_W-1:0] RST_DIV = 15'h0000;
  localparam logic [TRIM_W-1:0] RST_TRIM = 9'h000;
  localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  localparam logic [SEL_W-1:0] SRC_SYSTEM_CLOCK = 4'h0;
  localparam logic [SEL_W-1:0] SRC_PERIPHERAL_BUS_CLOCK = 4'h1;
  localparam logic [SEL_W-1:0] SRC_PRIMARY_OSC = 4'h2;
  localparam logic [SEL_W-1:0] SRC_FAST_RC_OSC = 4'h3;
  localparam logic [SEL_W-1:0] SRC_LOW_POWER_RC_OSC = 4'h4;
  localparam logic [SEL_W-1:0] SRC_SECONDARY_OSC = 4'h5;
  localparam logic [SEL_W-1:0] SRC_RESERVED_6 = 4'h6;
  localparam logic [SEL_W-1:0] SRC_SYSTEM_PLL = 4'h7;
  localparam logic [SEL_W-1:0] SRC_EXTERNAL_REFERENCE_INPUT = 4'h8;
  localparam logic [SEL_W-1:0] SRC_BACKUP_RC_OSC = 4'h9;

  localparam int unsigned SYNC_STAGES = 3;
endpackage

// ---- hw/rco_top.sv ----
// Reference clock output generator: register slave, source selection, switching and pin drive.
module rco_top
  import rco_pkg::*;
#(
  parameter int unsigned NSRC = rco_pkg::NUM_SRC
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [rco_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [rco_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [rco_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        peripheral_bus_clock,
  input  wire logic                        primary_osc,
  input  wire logic                        fast_rc_osc,
  input  wire logic                        low_power_rc_osc,
  input  wire logic                        secondary_osc,
  input  wire logic                        system_pll,
  input  wire logic                        external_reference_input,
  input  wire logic                        backup_rc_osc,
  input  wire logic                        idle_mode,
  input  wire logic                        sleep_mode,
  output logic                             refclk_out_pin
);
  import rco_pkg::*;

  // Software-visible fields, as last written; hardware clears the switch flag and drives the request status.
  logic [DIV_W-1:0]  integer_divider;
  logic [TRIM_W-1:0] fractional_trim;
  logic [SEL_W-1:0]  source_select;
  logic              module_on;
  logic              stop_in_idle;
  logic              pin_enable;
  logic              run_in_sleep;
  logic              divider_switch;
  logic              request_active;

  // Values the divider actually uses.
  logic [DIV_W-1:0]  work_div;
  logic [TRIM_W-1:0] work_trim;
  logic [SEL_W-1:0]  work_sel;

  logic [NSRC-1:0]   src_raw;
  logic [NSRC-1:0]   src_rise;
  logic              src_tick;
  logic              run;
  logic              sleep_ok;
  logic              clk_level;
  logic              div_fall;
  logic              div_stopped;
  logic              switch_done;
  logic              wr_control;
  logic              wr_trim;
  logic [DATA_W-1:0] next_rdata;

  assign wr_control = reg_write & (reg_addr == OFS_CONTROL);
  assign wr_trim = reg_write & (reg_addr == OFS_TRIM);

  // Index 0 is the system clock itself and needs no sampling.
  assign src_raw = {backup_rc_osc, external_reference_input, system_pll, 1'b0,
                    secondary_osc, low_power_rc_osc, fast_rc_osc, primary_osc,
                    peripheral_bus_clock, 1'b0};

  // Each asynchronous source passes three flops; an edge counts once stages two and three agree.
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_sync
      logic [SYNC_STAGES-1:0] stage;
      logic                   level;
      logic                   prev;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage <= '0;
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], src_raw[i]};
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
          level <= stage[2];
        end
      end
      // Level and history stay local, so each flop has one process writing it.
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev <= 1'b0;
        end else begin
          prev <= level;
        end
      end
      assign src_rise[i] = level & ~prev;
    end
  endgenerate

  always_comb begin
    src_tick = 1'b0;
    unique case (work_sel)
      SRC_SYSTEM_CLOCK: src_tick = 1'b1;
      SRC_PERIPHERAL_BUS_CLOCK,
      SRC_PRIMARY_OSC,
      SRC_FAST_RC_OSC,
      SRC_LOW_POWER_RC_OSC,
      SRC_SECONDARY_OSC,
      SRC_SYSTEM_PLL,
      SRC_EXTERNAL_REFERENCE_INPUT,
      SRC_BACKUP_RC_OSC: src_tick = src_rise[work_sel];
      default: src_tick = 1'b0;
    endcase
  end

  assign sleep_ok = run_in_sleep & (work_sel != SRC_SYSTEM_CLOCK) &
                    (work_sel != SRC_PERIPHERAL_BUS_CLOCK);

  assign run = module_on & ~(stop_in_idle & idle_mode) & ~(sleep_mode & ~sleep_ok);

  rco_frac_div #(
    .DW (DIV_W),
    .TW (TRIM_W)
  ) u_div (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .tick      (src_tick),
    .run       (run),
    .divisor   (work_div),
    .trim      (work_trim),
    .clk_level (clk_level),
    .fall      (div_fall),
    .stopped   (div_stopped)
  );

  // A switch lands only on a falling edge or while stopped, so the new period starts clean.
  assign switch_done = divider_switch & (div_fall | div_stopped);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_on <= RST_BIT;
      stop_in_idle <= RST_BIT;
      pin_enable <= RST_BIT;
      run_in_sleep <= RST_BIT;
      source_select <= RST_SEL;
      integer_divider <= RST_DIV;
    end else if (wr_control) begin
      module_on <= reg_wdata[POS_ON];
      stop_in_idle <= reg_wdata[POS_STOP_IN_IDLE];
      pin_enable <= reg_wdata[POS_OE];
      run_in_sleep <= reg_wdata[POS_RUN_IN_SLEEP];
      source_select <= reg_wdata[POS_SEL_HI:POS_SEL_LO];
      integer_divider <= reg_wdata[POS_DIV_HI:POS_DIV_LO];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fractional_trim <= RST_TRIM;
    end else if (wr_trim) begin
      fractional_trim <= reg_wdata[POS_TRIM_HI:POS_TRIM_LO];
    end
  end

  // Switch flag, a software set wins over completion.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_switch <= RST_BIT;
    end else if (wr_control && reg_wdata[POS_SWITCH]) begin
      divider_switch <= 1'b1;
    end else if (switch_done) begin
      divider_switch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_div <= RST_DIV;
      work_trim <= RST_TRIM;
      work_sel <= RST_SEL;
    end else if ((!module_on && div_stopped) || switch_done) begin
      work_div <= integer_divider;
      work_trim <= fractional_trim;
      work_sel <= source_select;
    end
  end

  // Request follows enable once the output has settled low.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_active <= RST_BIT;
    end else if (module_on) begin
      request_active <= 1'b1;
    end else if (div_stopped) begin
      request_active <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refclk_out_pin <= 1'b0;
    end else begin
      refclk_out_pin <= clk_level & pin_enable & request_active;
    end
  end

  always_comb begin
    next_rdata = RD_ZERO;
    if (reg_read && reg_addr == OFS_CONTROL) begin
      next_rdata[POS_DIV_HI:POS_DIV_LO] = integer_divider;
      next_rdata[POS_ON] = module_on;
      next_rdata[POS_STOP_IN_IDLE] = stop_in_idle;
      next_rdata[POS_OE] = pin_enable;
      next_rdata[POS_RUN_IN_SLEEP] = run_in_sleep;
      next_rdata[POS_SWITCH] = divider_switch;
      next_rdata[POS_ACTIVE] = request_active;
      next_rdata[POS_SEL_HI:POS_SEL_LO] = source_select;
    end else if (reg_read && reg_addr == OFS_TRIM) begin
      next_rdata[POS_TRIM_HI:POS_TRIM_LO] = fractional_trim;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RD_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// ---- verif/rco_checker_assertions.sv ----
// Checker of register readback and pin behaviour of the reference clock output.
module rco_checker
  import rco_pkg::*;
#(
  parameter int unsigned NSRC = rco_pkg::NUM_SRC
) (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic [rco_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rco_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_write,
  input wire logic                       reg_read,
  input wire logic [rco_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       idle_mode,
  input wire logic                       sleep_mode,
  input wire logic                       refclk_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import rco_pkg::*;
  logic [DATA_W-1:0] ctl;
  logic              rd_ctl;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  assign rd_ctl = reg_read && reg_addr == OFS_CONTROL;
  // Shadow of the last control word, so pin rules can be judged from the ports alone.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= RD_ZERO;
    end else if (reg_write && reg_addr == OFS_CONTROL) begin
      ctl <= reg_wdata;
    end
  end
  sequence s_idle_hold;
    (ctl[POS_STOP_IN_IDLE] && idle_mode)[*4];
  endsequence
  sequence s_sleep_hold;
    (sleep_mode && !ctl[POS_RUN_IN_SLEEP])[*4];
  endsequence
  sequence s_sleep_src01;
    (sleep_mode && ctl[3:1] == 3'h0)[*4];
  endsequence
  a_rsvd_ctl_zero: assert property (rd_ctl |=> (reg_rdata & 32'h8000_44F0) == RD_ZERO)
    else $error("reserved control bits read non-zero");
  a_trim_rsvd_zero: assert property (
    reg_read && reg_addr == OFS_TRIM |=> reg_rdata[22:0] == 23'h00_0000)
    else $error("reserved trim bits read non-zero");
  a_ctl_readback: assert property (
    rd_ctl |=> (reg_rdata & 32'h7FFF_B80F) == ($past(ctl) & 32'h7FFF_B80F))
    else $error("control readback differs from written value");
  a_active_on: assert property (
    rd_ctl && ctl[POS_ON] && $past(ctl[POS_ON]) |=> reg_rdata[POS_ACTIVE])
    else $error("request status low while enabled");
  a_pin_low_off: assert property ((!ctl[POS_OE])[*3] |-> !refclk_out_pin)
    else $error("pin high while output enable clear");
  a_rise_enabled: assert property (
    $rose(refclk_out_pin) |-> $past(ctl[POS_ON], 2) && $past(ctl[POS_OE]))
    else $error("pin rose while module or output disabled");
  a_idle_halts: assert property (s_idle_hold |-> !$rose(refclk_out_pin))
    else $error("pin rose while halted in idle");
  a_sleep_halts: assert property (s_sleep_hold |-> !$rose(refclk_out_pin))
    else $error("pin rose in sleep without run bit");
  a_sleep_src_ign: assert property (s_sleep_src01 |-> !$rose(refclk_out_pin))
    else $error("pin rose in sleep from a stopping source");
endmodule

bind rco_top rco_checker #(.NSRC(NSRC)) rco_checker_inst (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .idle_mode, .sleep_mode, .refclk_out_pin
);

// ---- verif/rco_src_model.sv ----
// Model of the free-running oscillators that feed the reference clock output.
module rco_src_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  output logic      [7:0] osc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt;
  // Levels last at least four cycles, so every edge survives the input synchroniser.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 10'h000;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end
  assign osc = cnt[9:2];
endmodule

// ---- verif/tb.sv ----
// Self-checking testbench of the reference clock output.
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rco_pkg::*;
  typedef struct {
    logic [31:0] ctl;
    logic [8:0]  trim;
    logic        idle;
    logic        sleep;
    int          cyc;
  } rco_row_t;
  logic              sys_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_write;
  logic              reg_read;
  logic              idle_mode;
  logic              sleep_mode;
  logic              refclk_out_pin;
  logic [7:0]        osc;
  logic [DATA_W-1:0] cur;
  logic [DATA_W-1:0] d;
  int                g;
  int                num_errors;
  int                cmp_count;
  int                cycles;
  // Cycles for two output periods; zero means no rising edge at all.
  rco_row_t rows [0:20] = '{
    '{32'h0001_9000, 9'h000, 0, 0, 4}, '{32'h0002_9000, 9'h000, 0, 0, 8},
    '{32'h0001_9000, 9'h080, 0, 0, 5}, '{32'h0000_9000, 9'h100, 0, 0, 4},
    '{32'h0001_9001, 9'h000, 0, 0, 32}, '{32'h0001_9002, 9'h000, 0, 0, 64},
    '{32'h0001_9003, 9'h000, 0, 0, 128}, '{32'h0001_9004, 9'h000, 0, 0, 256},
    '{32'h0001_9005, 9'h000, 0, 0, 512}, '{32'h0001_9007, 9'h000, 0, 0, 1024},
    '{32'h0001_9008, 9'h000, 0, 0, 2048}, '{32'h0001_9009, 9'h000, 0, 0, 4096},
    '{32'h0001_9006, 9'h000, 0, 0, 0}, '{32'h0001_900A, 9'h000, 0, 0, 0},
    '{32'h0001_B000, 9'h000, 1, 0, 0}, '{32'h0001_9000, 9'h000, 1, 0, 4},
    '{32'h0001_9000, 9'h000, 0, 1, 0}, '{32'h0001_9800, 9'h000, 0, 1, 0},
    '{32'h0001_9802, 9'h000, 0, 1, 64}, '{32'h0001_8000, 9'h000, 0, 0, 0},
    '{32'h0000_9000, 9'h000, 0, 0, 4}};
  rco_top #(.NSRC(NUM_SRC)) rco_top_inst (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .peripheral_bus_clock(osc[0]), .primary_osc(osc[1]), .fast_rc_osc(osc[2]),
    .low_power_rc_osc(osc[3]), .secondary_osc(osc[4]), .system_pll(osc[5]),
    .external_reference_input(osc[6]), .backup_rc_osc(osc[7]),
    .idle_mode, .sleep_mode, .refclk_out_pin
  );
  rco_src_model rco_src_model_inst (.sys_clk, .rst_n, .osc);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic wait_act(input logic v);
    logic [31:0] r;
    r = {32{~v}};
    for (int i = 0; i < 1000 && r[POS_ACTIVE] !== v; i++) rd(OFS_CONTROL, r);
    `CHK("request status", v, r[POS_ACTIVE])
  endtask
  task automatic setup(input rco_row_t r);
    @(posedge sys_clk);
    idle_mode <= 1'b0;
    sleep_mode <= 1'b0;
    // Fields written while off.
    // The enabling write only arms its own fields, so they land one write ahead of it.
    wr(OFS_CONTROL, cur & 32'hFFFF_7FFF);
    wait_act(1'b0);
    wr(OFS_TRIM, {r.trim, 23'h00_0000});
    wr(OFS_CONTROL, r.ctl & 32'hFFFF_7FFF);
    wr(OFS_CONTROL, r.ctl);
    wait_act(r.ctl[POS_ON]);
    cur = r.ctl;
    @(posedge sys_clk);
    idle_mode <= r.idle;
    sleep_mode <= r.sleep;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic meas(input int e, output int c);
    int  n;
    int  t0;
    int  lim;
    logic p;
    n = 0;
    c = 0;
    t0 = 0;
    p = refclk_out_pin;
    lim = e ? 2 * e + 40 : 200;
    for (int i = 0; i < lim && n < 3; i++) begin
      @(negedge sys_clk);
      if (refclk_out_pin === 1'b1 && p === 1'b0) begin
        n++;
        if (n == 1) t0 = i;
        if (n == 3) c = i - t0;
      end
      p = refclk_out_pin;
    end
    if (e == 0) c = n;
  endtask
  initial begin
    {rst_n, reg_addr, reg_wdata, reg_write, reg_read, idle_mode, sleep_mode} = '0;
    {num_errors, cmp_count, cycles} = '0;
    cur = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, d);
    `CHK("control reset", 32'h0, d)
    rd(OFS_TRIM, d);
    `CHK("trim reset", 32'h0, d)
    wr(OFS_CONTROL, 32'hFFFF_7DF5);
    rd(OFS_CONTROL, d);
    `CHK("control fields", 32'h7FFF_3805, d)
    wr(OFS_TRIM, 32'hFFFF_FFFF);
    rd(OFS_TRIM, d);
    `CHK("trim fields", 32'hFF80_0000, d)
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, d);
    `CHK("unmapped read", 32'h0, d)
    foreach (rows[i]) begin
      setup(rows[i]);
      meas(rows[i].cyc, g);
      `CHK("output cycles", rows[i].cyc, g)
    end
    // A nonzero divisor is needed, or a held trim could not show at all.
    setup(rows[0]);
    wr(OFS_TRIM, 32'h8000_0000);
    meas(4, g);
    `CHK("held trim", 4, g)
    wr(OFS_CONTROL, 32'h0001_9200);
    d = '1;
    for (int i = 0; i < 20 && d[POS_SWITCH] !== 1'b0; i++) rd(OFS_CONTROL, d);
    `CHK("switch bit", 1'b0, d[POS_SWITCH])
    repeat (8) @(posedge sys_clk);
    meas(6, g);
    `CHK("switched trim", 6, g)
    setup(rows[3]);
    meas(4, g);
    `CHK("trim ignored", 4, g)
    // Reset in mid-run drops the pin at once and clears every field.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(negedge sys_clk);
    `CHK("pin in reset", 1'b0, refclk_out_pin)
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, d);
    `CHK("control after reset", 32'h0, d)
    test_done();
  end
endmodule
